// [uls_core.sv]
/*
  Line status flags and modem control outputs of one UART channel, with a
  classic Wishbone slave, sticky interrupt status and mask.
  Assumes the rest of the channel (transmit path, receive FIFO, baud timing)
  runs on clk_i and reports its state through the channel ports below.
*/
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "uls_regs.svh"
module uls_core (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins
  input wire logic rx_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  // Transmit path
  output logic tx_wr_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_load_shift_i,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_shift_empty_i,
  // Receive path
  input wire logic bit_tick_i,
  input wire logic rx_done_i,
  input wire logic rx_stop_ok_i,
  input wire logic rx_top_valid_i,
  input wire logic rx_top_fe_i,
  input wire logic rx_fifo_err_any_i,
  input wire logic rx_above_trig_i,
  output logic brk_push_o,
  output logic fifo_en_o,
  // Interrupt
  output logic irq_o
);
  import uls_pkg::*;

  uls_main_s r;
  uls_main_s n;

  logic rx_sync;
  logic brk_pulse;
  logic fifo_en;
  logic wr;
  logic rd;
  logic hit_mcr;
  logic hit_lsr;
  logic hit_tx;
  logic hit_ctrl;
  logic hit_ists;
  logic hit_imask;
  logic rd_lsr;
  logic wr_tx;
  logic thre_set;
  logic fifo_err_set;
  logic fe_set;
  logic temt;
  logic [3:0] irq_ev;
  logic [3:0] irq_clr;
  logic [7:0] line_status;
  logic req;
  logic wr_mcr;
  logic wr_ctrl;
  logic wr_imask;
  logic wr_ists;
  logic fifo_empty_rise;
  logic fe_top;
  logic rts_flow_hold;
  logic irq_sticky;
  logic irq_thre;

  ////////////////////////////////////////////////////////////////////////////
  // Receive line and break detection

  uls_sync2 #(
    .RST_VAL(1'b1)
  ) u_rx_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(rx_i),
    .q_o(rx_sync)
  );

  // The break detector only ever sees the synchronised line
  uls_break_det u_break (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx_i(rx_sync),
    .bit_tick_i(bit_tick_i),
    .frame_bits_i(r.ctrl[`ULS_CTRL_FRAME_MSB:`ULS_CTRL_FRAME_LSB]),
    .brk_o(brk_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;

    // Bus decode; ack is given one cycle after the request and dropped after
    // A request is taken once: the standing ack blocks a second take
    req = cyc_i & stb_i & ~r.ack;
    n.ack = req;
    wr = req & we_i & sel_i[0];
    rd = req & ~we_i;

    // Address decode; the low two bits must be zero for a hit
    hit_mcr = 1'b0;
    hit_lsr = 1'b0;
    hit_tx = 1'b0;
    hit_ctrl = 1'b0;
    hit_ists = 1'b0;
    hit_imask = 1'b0;
    case (adr_i)
      `ULS_OFF_MODEM_CTRL: begin
        hit_mcr = 1'b1;
      end
      `ULS_OFF_LINE_STATUS: begin
        hit_lsr = 1'b1;
      end
      `ULS_OFF_TX_HOLD: begin
        hit_tx = 1'b1;
      end
      `ULS_OFF_CTRL: begin
        hit_ctrl = 1'b1;
      end
      `ULS_OFF_IRQ_STATUS: begin
        hit_ists = 1'b1;
      end
      `ULS_OFF_IRQ_MASK: begin
        hit_imask = 1'b1;
      end
      default: begin
        // Unmapped offsets are acked, read zero and ignore writes
      end
    endcase
    rd_lsr = rd & hit_lsr;
    wr_tx = wr & hit_tx;
    wr_mcr = wr & hit_mcr;
    wr_ctrl = wr & hit_ctrl;
    wr_imask = wr & hit_imask;
    wr_ists = wr & hit_ists;
    fifo_en = r.ctrl[`ULS_CTRL_FIFO_EN];

    // Register writes
    if (wr_mcr) begin
      n.modem_control = dat_i[7:0] & `ULS_MCR_WMASK;
    end
    if (wr_ctrl) begin
      n.ctrl = dat_i[7:0] & `ULS_CTRL_WMASK;
    end
    if (wr_imask) begin
      n.irq_mask = dat_i[3:0];
    end

    // Character written to the holding register goes on to the transmit path
    n.tx_wr = wr_tx;
    if (wr_tx) begin
      n.tx_data = dat_i[7:0];
    end

    // Holding register empty; a set in the same cycle as a write wins
    // Only the edge into empty sets the flag in FIFO mode,
    // so a later write into a still-empty FIFO clears it until the next edge into empty
    fifo_empty_rise = tx_fifo_empty_i & ~r.fifo_empty_d;
    if (fifo_en) begin
      thre_set = fifo_empty_rise;
    end else begin
      thre_set = tx_load_shift_i;
    end
    n.thre = thre_set | (r.thre & ~wr_tx);
    n.fifo_empty_d = tx_fifo_empty_i;

    // Transmitter empty
    if (fifo_en) begin
      temt = tx_fifo_empty_i & tx_shift_empty_i;
    end else begin
      temt = r.thre & tx_shift_empty_i;
    end

    // FIFO data error, re-set while a tagged character is still present
    fifo_err_set = fifo_en & rx_fifo_err_any_i;
    n.fifo_err = fifo_err_set | (r.fifo_err & ~rd_lsr);

    // Break flag, held until the status is read
    n.brk = brk_pulse | (r.brk & ~rd_lsr);
    n.brk_push = brk_pulse & fifo_en;

    // Framing error: latched per character, or the top character's tag
    fe_set = rx_done_i & ~rx_stop_ok_i;
    fe_top = rx_top_valid_i & rx_top_fe_i;
    if (fifo_en) begin
      n.fe = fe_top;
    end else begin
      n.fe = fe_set | (r.fe & ~rd_lsr);
    end

    // Line status view
    line_status = 8'h00;
    line_status[`ULS_LSR_FIFO_ERR] = r.fifo_err;
    line_status[`ULS_LSR_TEMT] = temt;
    line_status[`ULS_LSR_THRE] = r.thre;
    line_status[`ULS_LSR_BREAK] = r.brk;
    line_status[`ULS_LSR_FRAME] = r.fe;

    // Sticky interrupt status, cleared by writing ones; events win
    irq_ev = 4'h0;
    irq_ev[`ULS_IRQ_THRE] = thre_set;
    irq_ev[`ULS_IRQ_BREAK] = brk_pulse;
    irq_ev[`ULS_IRQ_FIFO_ERR] = fifo_err_set & ~r.fifo_err;
    irq_ev[`ULS_IRQ_FRAME] = fifo_en ? (n.fe & ~r.fe) : fe_set;
    irq_clr = wr_ists ? dat_i[3:0] : 4'h0;
    n.irq_sts = irq_ev | (r.irq_sts & ~irq_clr);

    // A status read clears its flags at the edge that latches the read data,
    // so software always sees the value from before the clear
    // Read data, zero for unmapped and write-only offsets
    n.rdata = 32'h0000_0000;
    if (rd) begin
      if (hit_mcr) begin
        n.rdata = {24'h00_0000, r.modem_control};
      end else if (hit_lsr) begin
        n.rdata = {24'h00_0000, line_status};
      end else if (hit_ctrl) begin
        n.rdata = {24'h00_0000, r.ctrl};
      end else if (hit_ists) begin
        n.rdata = {28'h000_0000, r.irq_sts};
      end else if (hit_imask) begin
        n.rdata = {28'h000_0000, r.irq_mask};
      end
    end

    // Modem outputs, active low on the pins; autoflow can only take RTS back
    rts_flow_hold = r.modem_control[`ULS_MCR_AUTOFLOW] & rx_above_trig_i;
    n.rts_n = ~(r.modem_control[`ULS_MCR_RTS] & ~rts_flow_hold);
    n.dtr_n = ~r.modem_control[`ULS_MCR_DTR];

    // Interrupt level
    irq_sticky = |(r.irq_sts & r.irq_mask);
    irq_thre = r.thre & r.ctrl[`ULS_CTRL_THRE_IE];
    n.irq = irq_sticky | irq_thre;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Pins idle high and the holding register starts empty
      r.ack <= 1'b0;
      r.rdata <= 32'h0000_0000;
      r.modem_control <= `ULS_MCR_RESET;
      r.ctrl <= `ULS_CTRL_RESET;
      r.irq_sts <= `ULS_IRQ_RESET;
      r.irq_mask <= `ULS_IRQ_RESET;
      r.thre <= 1'b1;
      r.fifo_err <= 1'b0;
      r.brk <= 1'b0;
      r.fe <= 1'b0;
      r.fifo_empty_d <= 1'b1;
      r.rts_n <= 1'b1;
      r.dtr_n <= 1'b1;
      r.tx_wr <= 1'b0;
      r.tx_data <= 8'h00;
      r.brk_push <= 1'b0;
      r.irq <= 1'b0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ack_o = r.ack;
  assign dat_o = r.rdata;
  assign rts_n_o = r.rts_n;
  assign dtr_n_o = r.dtr_n;
  assign tx_wr_o = r.tx_wr;
  assign tx_data_o = r.tx_data;
  assign brk_push_o = r.brk_push;
  assign fifo_en_o = r.ctrl[`ULS_CTRL_FIFO_EN];
  assign irq_o = r.irq;
endmodule

// [uls_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  line status and modem output block.
  Assumes a Wishbone slave with byte addresses and one 32-bit word per register.
*/
`ifndef ULS_REGS_SVH
`define ULS_REGS_SVH

// Byte offsets
`define ULS_OFF_MODEM_CTRL 8'h00
`define ULS_OFF_LINE_STATUS 8'h04
`define ULS_OFF_TX_HOLD 8'h08
`define ULS_OFF_CTRL 8'h0C
`define ULS_OFF_IRQ_STATUS 8'h10
`define ULS_OFF_IRQ_MASK 8'h14

// Modem control fields; bits 7:6 reserved and read as zero
`define ULS_MCR_DTR 0
`define ULS_MCR_RTS 1
`define ULS_MCR_AUTOFLOW 5
`define ULS_MCR_WMASK 8'h3F
`define ULS_MCR_RESET 8'h00

// Line status fields; bits 2:0 are kept elsewhere in the channel and read zero
`define ULS_LSR_FRAME 3
`define ULS_LSR_BREAK 4
`define ULS_LSR_THRE 5
`define ULS_LSR_TEMT 6
`define ULS_LSR_FIFO_ERR 7

// Control fields
`define ULS_CTRL_FIFO_EN 0
`define ULS_CTRL_THRE_IE 1
`define ULS_CTRL_FRAME_LSB 4
`define ULS_CTRL_FRAME_MSB 7
`define ULS_CTRL_WMASK 8'hF3
`define ULS_CTRL_RESET 8'hA0

// Interrupt status and mask fields
`define ULS_IRQ_THRE 0
`define ULS_IRQ_BREAK 1
`define ULS_IRQ_FIFO_ERR 2
`define ULS_IRQ_FRAME 3
`define ULS_IRQ_RESET 4'h0

// Break detector
`define ULS_FRAME_BITS_MIN 4'h1

`endif

// [uls_pkg.sv]
/*
  Types shared by the line status and modem output block.
  Assumes uls_regs.svh for all numeric constants.
*/
package uls_pkg;

  typedef enum logic [2:0] {
    BRK_IDLE = 3'b001,
    BRK_COUNT = 3'b010,
    BRK_HELD = 3'b100
  } uls_brk_e;

  typedef struct packed {
    uls_brk_e st;
    logic [3:0] cnt;
    logic brk;
  } uls_brk_s;

  typedef struct packed {
    logic meta;
    logic sync;
  } uls_sync_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] modem_control;
    logic [7:0] ctrl;
    logic [3:0] irq_sts;
    logic [3:0] irq_mask;
    logic thre;
    logic fifo_err;
    logic brk;
    logic fe;
    logic fifo_empty_d;
    logic rts_n;
    logic dtr_n;
    logic tx_wr;
    logic [7:0] tx_data;
    logic brk_push;
    logic irq;
  } uls_main_s;

endpackage

// [uls_sync2.sv]
/*
  Two flip-flop synchroniser for one level from a pin.
  Assumes the level changes slowly against clk_i.
*/
`timescale 1ns/10ps
module uls_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  import uls_pkg::*;

  uls_sync_s r;
  uls_sync_s n;

  always_comb begin
    n.meta = d_i;
    n.sync = r.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.meta <= RST_VAL;
      r.sync <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  assign q_o = r.sync;
endmodule

// [uls_break_det.sv]
/*
  Break detector: pulses once when the receive line has stayed low for a
  whole character frame, then waits for the line to return high.
  Assumes a synchronised line level and a one-cycle pulse per bit time.
*/
`timescale 1ns/10ps
`include "uls_regs.svh"
module uls_break_det (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_i,
  input wire logic bit_tick_i,
  input wire logic [3:0] frame_bits_i,
  output logic brk_o
);
  import uls_pkg::*;

  uls_brk_s r;
  uls_brk_s n;
  logic [3:0] cnt_inc;
  logic [3:0] frame_len;

  always_comb begin
    cnt_inc = r.cnt + 4'h1;
    frame_len = (frame_bits_i < `ULS_FRAME_BITS_MIN) ? `ULS_FRAME_BITS_MIN : frame_bits_i;
    n = r;
    n.brk = 1'b0;
    unique case (r.st)
      BRK_IDLE: begin
        if (!rx_i) begin
          n.st = BRK_COUNT;
          n.cnt = 4'h0;
        end
      end
      BRK_COUNT: begin
        if (rx_i) begin
          n.st = BRK_IDLE;
        end else if (bit_tick_i) begin
          if (cnt_inc == frame_len) begin
            n.brk = 1'b1;
            n.st = BRK_HELD;
          end else begin
            n.cnt = cnt_inc;
          end
        end
      end
      BRK_HELD: begin
        if (rx_i) begin
          n.st = BRK_IDLE;
        end
      end
      default: begin
        n.st = BRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.st <= BRK_IDLE;
      r.cnt <= 4'h0;
      r.brk <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign brk_o = r.brk;
endmodule

// [uls_core_asserts.sv]
/*
  Port checker for uls_core.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module uls_core_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic tx_wr_o,
  input wire logic [7:0] tx_data_o,
  input wire logic brk_push_o,
  input wire logic fifo_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic mw;
  assign mw = ack_o && we_i && adr_i == 8'h00 && sel_i[0];
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_once:
    assert property (ack_o |=> !ack_o) else $error("ack held too long");
  chk_ack_next:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  chk_dat_idle:
    assert property (!ack_o |-> dat_o == '0) else $error("read data outside ack");
  chk_dat_high:
    assert property (ack_o && !we_i |-> dat_o[31:8] == '0) else $error("upper bits set");
  chk_dtr_pin:
    assert property (mw |=> dtr_n_o == !$past(dat_i[0])) else $error("dtr pin wrong");
  chk_rts_pin:
    assert property (mw && !dat_i[5] |=> rts_n_o == !$past(dat_i[1])) else $error("rts wrong");
  chk_tx_write:
    assert property (tx_wr_o |-> ack_o && we_i && adr_i == 8'h08) else $error("stray tx write");
  chk_tx_data:
    assert property (tx_wr_o |-> tx_data_o == dat_i[7:0]) else $error("tx data wrong");
  chk_brk_once:
    assert property (brk_push_o |=> !brk_push_o) else $error("break push repeated");
  chk_brk_fifo:
    assert property (brk_push_o |-> fifo_en_o) else $error("break push without fifo");
endmodule
bind uls_core uls_core_asserts chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .rts_n_o, .dtr_n_o, .tx_wr_o, .tx_data_o, .brk_push_o, .fifo_en_o);

// [uls_peer.sv]
/*
  Model of the channel transmit path and bit timing around uls_core.
  Assumes tx_wr_i is a one-cycle pulse on clk_i.
*/
`timescale 1ns/10ps
module uls_peer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_wr_i,
  output logic tx_load_shift_o,
  output logic tx_fifo_empty_o,
  output logic tx_shift_empty_o,
  output logic bit_tick_o
);
  logic [3:0] hd;
  logic [3:0] sh;
  logic [1:0] tk;
  ////////////////////////////////////////////////////////////////////////////
  // Character waits in holding, then shifts out slowly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hd <= '0;
      sh <= '0;
      tk <= '0;
    end else begin
      tk <= tk + 2'h1;
      if (tx_wr_i) hd <= 4'h6;
      else if (hd != 4'h0) hd <= hd - 4'h1;
      if (hd == 4'h1) sh <= 4'h8;
      else if (sh != 4'h0) sh <= sh - 4'h1;
    end
  end
  assign tx_load_shift_o = hd == 4'h1;
  assign tx_fifo_empty_o = hd == 4'h0;
  assign tx_shift_empty_o = sh == 4'h0;
  assign bit_tick_o = tk == 2'h0;
endmodule

// [tb.sv]
/*
  Self-checking bench for uls_core over classic Wishbone.
  Assumes uls_peer stands for the transmit path and bit timing.
*/
`timescale 1ns/10ps
module tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = '0;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic ack_o, rts_n_o, dtr_n_o, tx_wr_o, brk_push_o, fifo_en_o, irq_o;
  logic [7:0] tx_data_o;
  logic rx_i = 1, bit_tick_i, rx_done_i = 0, rx_stop_ok_i = 1, rx_top_valid_i = 0;
  logic rx_top_fe_i = 0, rx_fifo_err_any_i = 0, rx_above_trig_i = 0;
  logic tx_load_shift_i, tx_fifo_empty_i, tx_shift_empty_i;
  int mismatches = 0, total_checks = 0, pushes = 0, p;
  always #10 clk_i = ~clk_i;
  uls_core dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .rx_i, .rts_n_o, .dtr_n_o, .tx_wr_o, .tx_data_o, .tx_load_shift_i,
    .tx_fifo_empty_i, .tx_shift_empty_i, .bit_tick_i, .rx_done_i, .rx_stop_ok_i,
    .rx_top_valid_i, .rx_top_fe_i, .rx_fifo_err_any_i, .rx_above_trig_i, .brk_push_o,
    .fifo_en_o, .irq_o);
  uls_peer peer_u (.clk_i, .rst_i, .tx_wr_i(tx_wr_o), .tx_load_shift_o(tx_load_shift_i),
    .tx_fifo_empty_o(tx_fifo_empty_i), .tx_shift_empty_o(tx_shift_empty_i),
    .bit_tick_o(bit_tick_i));
  always @(negedge clk_i) if (brk_push_o === 1'b1) pushes++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 64);
    if (n >= 64) begin
      mismatches++;
      complete_run();
    end
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, '0);
    chk(n, e, rd);
  endtask
  task automatic tk(input int c);
    repeat (c) @(negedge clk_i);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    tk(3);
    chk("dtr", 1, dtr_n_o);
    chk("irq", 0, irq_o);
    rdc("mcr", 8'h00, '0);
    rdc("ctrl", 8'h0C, 8'hA0);
    rdc("lsr", 8'h04, 8'h60);
    rdc("unmapped", 8'h20, '0);
    xfer(1, 8'h00, 8'hFF);
    rdc("mcr", 8'h00, 8'h3F);
    chk("rts", 0, rts_n_o);
    chk("dtr", 0, dtr_n_o);
    @(posedge clk_i);
    rx_above_trig_i <= 1;
    tk(2);
    chk("rts", 1, rts_n_o);
    xfer(1, 8'h00, 8'h03);
    tk(1);
    chk("rts", 0, rts_n_o);
    xfer(1, 8'h00, '0);
    tk(1);
    chk("dtr", 1, dtr_n_o);
    for (int m = 0; m < 2; m++) begin
      xfer(1, 8'h0C, 8'hA2 | m);
      tk(2);
      chk("irq", 1, irq_o);
      chk("fifo_en", m, fifo_en_o);
      xfer(1, 8'h08, 8'h5A);
      chk("txd", 8'h5A, tx_data_o);
      rdc("lsr", 8'h04, 8'h00);
      chk("irq", 0, irq_o);
      tk(20);
      rdc("lsr", 8'h04, 8'h60);
    end
    xfer(1, 8'h0C, 8'hA0);
    tk(2);
    chk("irq", 0, irq_o);
    xfer(1, 8'h14, 8'h01);
    tk(2);
    chk("irq", 1, irq_o);
    xfer(1, 8'h10, 8'h0F);
    tk(2);
    chk("irq", 0, irq_o);
    xfer(1, 8'h0C, 8'hA1);
    p = pushes;
    @(posedge clk_i);
    rx_i <= 0;
    rx_fifo_err_any_i <= 1;
    tk(120);
    chk("pushes", 1, pushes - p);
    @(posedge clk_i);
    rx_fifo_err_any_i <= 0;
    rdc("lsr", 8'h04, 8'hF0);
    rdc("lsr", 8'h04, 8'h60);
    @(posedge clk_i);
    rx_i <= 1;
    tk(10);
    for (int m = 0; m < 2; m++) begin
      xfer(1, 8'h0C, 8'hA0 | m);
      @(posedge clk_i);
      rx_stop_ok_i <= 0;
      rx_done_i <= 1;
      rx_top_valid_i <= m[0];
      rx_top_fe_i <= 1;
      @(posedge clk_i);
      rx_done_i <= 0;
      rx_stop_ok_i <= 1;
      rdc("lsr", 8'h04, 8'h68);
      rdc("lsr", 8'h04, m[0] ? 8'h68 : 8'h60);
    end
    complete_run();
  end
endmodule
